// *** design/psbp_port.sv ***
// Parallel setpoint bus port: pin sync, strobe capture, setpoint store, registers
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// RULE1: Controller parks strobes high, waits for start
// RULE2: Controller sets data and selector, drops strobe
// RULE3: Strobe low 100/20 ms, high 20 ms
// RULE4: Bits 1-8 setpoint, bits 9-11 selector
// RULE5: Strobe moves lines into setpoint storage
// RULE6: Release input low blocks coating enable
// RULE7: One composite error output for any fault
// RULE8: Lock parameter makes remote input panel lock; the remote input gates the panel here with lock on or off
// RULE9: Capture starts on strobe falling edge
// RULE10: Selector decodes to one of eight setpoints
// RULE11: Remote input high selects remote mode
// RULE12: Synchronise inputs, detect edges after sync
module psbp_port (
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic [7:0]  setpoint_byte_lines,
    input  wire logic [2:0]  parameter_selector_lines,
    input  wire logic        strobe_n,
    input  wire logic        system_release,
    input  wire logic        remote_manual,
    input  wire logic        trigger_active,
    input  wire logic        unit_fault,
    output logic             error_out,
    output logic             coating_enable,
    output logic             remote_mode,
    output logic             panel_enable,
    output logic [7:0]       recipe_index,
    output logic             setpoint_valid,
    input  wire logic        setpoint_ready,
    output logic [2:0]       setpoint_sel,
    output logic [7:0]       setpoint_data,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata
);
    localparam int SW = psbp_pkg::SYNC_W;
    localparam int FW = psbp_pkg::DATA_W + psbp_pkg::SEL_W;
    // Idle pin levels: strobe parked high, release and remote inactive
    localparam logic [SW-1:0] SYNC_IDLE = SW'(1) << psbp_pkg::POS_STROBE;

    logic [SW-1:0] meta_q;
    logic [SW-1:0] sync_q;
    logic          strobe_prev_q;
    logic          strobe_fall;
    logic [7:0]    data_s;
    logic [2:0]    sel_s;
    logic          release_s;
    logic          remote_s;
    logic [7:0]    setpt_q [8];
    logic          lock_param_q;
    logic          sw_fault_q;
    logic          overrun_q;
    logic [7:0]    xfer_cnt_q;
    logic          fifo_in_ready;
    logic [FW-1:0] fifo_out;
    logic          fifo_out_valid;
    logic [7:0]    reg_rdata_q;

    // Two-stage synchroniser; first stage is read only by the second.
    // Resets to idle levels so release and remote read inactive until the pins pass both stages.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            meta_q <= SYNC_IDLE;
            sync_q <= SYNC_IDLE;
        end else begin
            meta_q <= {remote_manual, strobe_n, system_release,
                       parameter_selector_lines, setpoint_byte_lines};
            sync_q <= meta_q; // RULE12
        end
    end

    // Field split of the synchronised vector
    assign data_s    = sync_q[psbp_pkg::POS_DATA +: psbp_pkg::DATA_W]; // RULE4
    assign sel_s     = sync_q[psbp_pkg::POS_SEL +: psbp_pkg::SEL_W];   // RULE4
    assign release_s = sync_q[psbp_pkg::POS_RELEASE];
    assign remote_s  = sync_q[psbp_pkg::POS_REMOTE];

    // Falling-edge detect on the synchronised strobe; reset high so no false edge
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            strobe_prev_q <= 1'b1;
        end else begin
            strobe_prev_q <= sync_q[psbp_pkg::POS_STROBE];
        end
    end
    assign strobe_fall = strobe_prev_q && !sync_q[psbp_pkg::POS_STROBE]; // RULE9 RULE12

    // Setpoint store: the edge writes the selected slot; data is stable by then
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            for (int i = 0; i < 8; i++) begin
                setpt_q[i] <= psbp_pkg::SETPT_RST;
            end
        end else if (strobe_fall) begin
            setpt_q[sel_s] <= data_s; // RULE5 RULE10
        end
    end

    // Recipe index is loaded from the data lines on a recipe-code edge
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            recipe_index <= psbp_pkg::SETPT_RST;
        end else if (strobe_fall && sel_s == psbp_pkg::SEL_RECIPE) begin
            recipe_index <= data_s; // RULE10
        end
    end

    // Captured transfers also go downstream; a full FIFO drops and flags overrun
    psbp_fifo #(
        .WIDTH (FW),
        .DEPTH (psbp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .in_valid  (strobe_fall),
        .in_ready  (fifo_in_ready),
        .in_data   ({sel_s, data_s}),
        .out_valid (fifo_out_valid),
        .out_ready (setpoint_ready),
        .out_data  (fifo_out)
    );
    assign setpoint_valid = fifo_out_valid;
    assign setpoint_sel   = fifo_out[psbp_pkg::DATA_W +: psbp_pkg::SEL_W];
    assign setpoint_data  = fifo_out[psbp_pkg::DATA_W-1:0];

    // Overrun is sticky; a new overrun wins over a software clear
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            overrun_q <= 1'b0;
        end else if (strobe_fall && !fifo_in_ready) begin
            overrun_q <= 1'b1;
        end else if (reg_wr && reg_addr == psbp_pkg::REG_STATUS && reg_wdata[0]) begin
            overrun_q <= 1'b0;
        end
    end

    // Transfer counter shows activity to software
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            xfer_cnt_q <= 8'h00;
        end else if (strobe_fall) begin
            xfer_cnt_q <= xfer_cnt_q + 8'h01;
        end
    end

    // Control register written by software
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            lock_param_q <= 1'b0;
            sw_fault_q   <= 1'b0;
        end else if (reg_wr && reg_addr == psbp_pkg::REG_CTRL) begin
            lock_param_q <= reg_wdata[psbp_pkg::CTRL_LOCK_BIT];
            sw_fault_q   <= reg_wdata[psbp_pkg::CTRL_FAULT_BIT];
        end
    end

    // Mode, release and error outputs, registered
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            remote_mode    <= 1'b0;
            panel_enable   <= 1'b1;
            coating_enable <= 1'b0;
            error_out      <= 1'b0;
        end else begin
            // The input gates the panel with lock on or off; with lock on, mode stays manual
            remote_mode    <= !lock_param_q && remote_s;  // RULE11 RULE8
            panel_enable   <= !remote_s; // RULE8
            coating_enable <= release_s && trigger_active; // RULE6
            error_out      <= unit_fault || sw_fault_q || overrun_q; // RULE7
        end
    end

    // Read data one cycle after the read strobe; unmapped reads give zero
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr < psbp_pkg::REG_CTRL) begin
                reg_rdata_q <= setpt_q[reg_addr[2:0]];
            end else if (reg_addr == psbp_pkg::REG_CTRL) begin
                reg_rdata_q <= {6'h00, sw_fault_q, lock_param_q};
            end else if (reg_addr == psbp_pkg::REG_STATUS) begin
                reg_rdata_q <= {3'h0, error_out, remote_mode, release_s,
                                fifo_out_valid, overrun_q};
            end else if (reg_addr == psbp_pkg::REG_COUNT) begin
                reg_rdata_q <= xfer_cnt_q;
            end else begin
                reg_rdata_q <= 8'h00;
            end
        end else begin
            reg_rdata_q <= 8'h00;
        end
    end
    assign reg_rdata = reg_rdata_q;

    // Coating may never be enabled while release is low
    release_gate_a: assert property (@(posedge sys_clk) disable iff (srst)
        !release_s |=> !coating_enable) else $error("coating enabled without release"); // RULE6
    // A strobe falling edge stores the byte in its slot
    strobe_store_a: assert property (@(posedge sys_clk) disable iff (srst)
        strobe_fall |=> setpt_q[$past(sel_s)] == $past(data_s))
        else $error("setpoint not stored on strobe edge"); // RULE5
    // Pin low reaches the edge detector after exactly sync delay
    edge_sync_a: assert property (@(posedge sys_clk) disable iff (srst)
        strobe_fall |-> $past(strobe_n, 3) && !$past(strobe_n, 2))
        else $error("strobe edge not from synchronised pin"); // RULE9
    // Unit fault or software fault drives error next cycle
    error_comp_a: assert property (@(posedge sys_clk) disable iff (srst)
        (unit_fault || sw_fault_q) |=> error_out) else $error("error output missed"); // RULE7
    // Remote mode follows input when lock is off
    remote_mode_a: assert property (@(posedge sys_clk) disable iff (srst)
        (!lock_param_q && remote_s) |=> remote_mode) else $error("remote mode not entered"); // RULE11
    // Lock on keeps mode manual and gates the panel
    panel_lock_a: assert property (@(posedge sys_clk) disable iff (srst)
        (lock_param_q && remote_s) |=> !remote_mode && !panel_enable)
        else $error("panel lock not applied"); // RULE8
    // Recipe code updates the recipe index
    recipe_sel_a: assert property (@(posedge sys_clk) disable iff (srst)
        (strobe_fall && sel_s == psbp_pkg::SEL_RECIPE) |=> recipe_index == $past(data_s))
        else $error("recipe index not updated"); // RULE10
    // Unsynchronised pin change cannot cause an edge within two cycles
    sync_delay_a: assert property (@(posedge sys_clk) disable iff (srst)
        ($fell(strobe_n) && sync_q[psbp_pkg::POS_STROBE]) |-> !strobe_fall ##1 !strobe_fall)
        else $error("edge seen before synchroniser"); // RULE12
endmodule

// *** design/psbp_pkg.sv ***
// Package of constants for the parallel setpoint bus port
package psbp_pkg;
    localparam int DATA_W      = 8;
    localparam int SEL_W       = 3;
    localparam int SYNC_W      = 14;
    // Bit positions in the synchronised input vector
    localparam int POS_DATA    = 0;
    localparam int POS_SEL     = 8;
    localparam int POS_RELEASE = 11;
    localparam int POS_STROBE  = 12;
    localparam int POS_REMOTE  = 13;
    localparam int FIFO_DEPTH  = 8;
    // Selector codes
    localparam logic [2:0] SEL_POWDER   = 3'h0;
    localparam logic [2:0] SEL_TOTALAIR = 3'h1;
    localparam logic [2:0] SEL_RINSE    = 3'h2;
    localparam logic [2:0] SEL_UNUSED   = 3'h3;
    localparam logic [2:0] SEL_HV       = 3'h4;
    localparam logic [2:0] SEL_CURRENT  = 3'h5;
    localparam logic [2:0] SEL_RECIPE   = 3'h6;
    localparam logic [2:0] SEL_DAILY    = 3'h7;
    localparam logic [7:0] SETPT_RST    = 8'h00;
    // Register offsets for the plain register port
    localparam logic [3:0] REG_SETPT0   = 4'h0; // 0..7: one per selector code
    localparam logic [3:0] REG_CTRL     = 4'h8; // Bit0 panel lock parameter, bit1 fault
    localparam logic [3:0] REG_STATUS   = 4'h9;
    localparam logic [3:0] REG_COUNT    = 4'ha;
    localparam int CTRL_LOCK_BIT = 0;
    localparam int CTRL_FAULT_BIT = 1;
endpackage

// *** design/psbp_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module psbp_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    // Full and empty come straight from the occupancy count
    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage has no reset; only pointers and count need a defined value
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers wrap; depth is a power of two
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// *** dv/psbp_plc_model.sv ***
// Behavioural supervising controller that drives the parallel setpoint lines
`timescale 1ns/1ps
module psbp_plc_model #(
    parameter int LONG_CYC  = 40,
    parameter int SHORT_CYC = 10,
    parameter int GAP_CYC   = 10
) (
    input  wire logic       sys_clk,
    input  wire logic       start,
    input  wire logic [2:0] req_sel,
    input  wire logic [7:0] req_data,
    output logic      [7:0] setpoint_byte_lines,
    output logic      [2:0] parameter_selector_lines,
    output logic            strobe_n,
    output logic            busy
);
    // Park the strobe high, then sit idle until the bench asks for a transfer
    initial begin
        strobe_n = 1'b1;
        busy = 1'b0;
        setpoint_byte_lines = 8'hff;
        parameter_selector_lines = 3'h7;
        forever begin
            @(posedge sys_clk);
            if (start) begin
                busy <= 1'b1;
                setpoint_byte_lines <= req_data;
                parameter_selector_lines <= req_sel;
                // Lines settle well before the strobe so the sampler sees stable data
                repeat (4) @(posedge sys_clk);
                strobe_n <= 1'b0;
                if (req_sel == psbp_pkg::SEL_RECIPE) begin
                    repeat (LONG_CYC) @(posedge sys_clk);
                end else begin
                    repeat (SHORT_CYC) @(posedge sys_clk);
                end
                strobe_n <= 1'b1;
                repeat (GAP_CYC) @(posedge sys_clk);
                // Lines no longer held: show the inverse so stale values cannot pass
                setpoint_byte_lines <= ~req_data;
                parameter_selector_lines <= ~req_sel;
                busy <= 1'b0;
            end
        end
    end
endmodule

// *** dv/psbp_port_test.sv ***
// Self-checking testbench for the parallel setpoint bus port
`timescale 1ns/1ps
module psbp_port_test;
    logic       sys_clk, srst, strobe_n, system_release, remote_manual;
    logic       trigger_active, unit_fault, error_out, coating_enable, remote_mode;
    logic       panel_enable, setpoint_valid, setpoint_ready, reg_wr, reg_rd, start, busy;
    logic [7:0] setpoint_byte_lines, recipe_index, setpoint_data, reg_wdata, reg_rdata;
    logic [7:0] req_data, rd;
    logic [2:0] parameter_selector_lines, setpoint_sel, req_sel;
    logic [3:0] reg_addr;
    int         failures, compares;

    // 250 MHz system clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    psbp_port uut (.sys_clk, .srst, .setpoint_byte_lines, .parameter_selector_lines,
        .strobe_n, .system_release, .remote_manual, .trigger_active, .unit_fault,
        .error_out, .coating_enable, .remote_mode, .panel_enable, .recipe_index,
        .setpoint_valid, .setpoint_ready, .setpoint_sel, .setpoint_data, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

    // Hold times shortened from milliseconds to cycles to keep the run short
    psbp_plc_model #(.LONG_CYC(40), .SHORT_CYC(10), .GAP_CYC(10)) plc (.sys_clk, .start,
        .req_sel, .req_data, .setpoint_byte_lines, .parameter_selector_lines, .strobe_n, .busy);

    task automatic test_done();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // check_bit samples at the falling edge so clocked updates have landed; check_byte compares the value passed at the call
    task automatic check_bit(string name, logic exp, ref logic got);
        @(negedge sys_clk);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
        @(posedge sys_clk);
    endtask

    task automatic check_byte(string name, logic [7:0] exp, logic [7:0] got);
        @(negedge sys_clk);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
        @(posedge sys_clk);
    endtask

    task automatic reg_write(logic [3:0] a, logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_read(logic [3:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
        @(posedge sys_clk);
    endtask

    // One strobed transfer through the controller model, bounded wait
    task automatic send(logic [2:0] s, logic [7:0] d);
        int n;
        n = 0;
        req_sel <= s;
        req_data <= d;
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        @(posedge sys_clk);
        while (busy === 1'b1) begin
            @(posedge sys_clk);
            n++;
            if (n > 200) begin
                failures++;
                $display("ERROR transfer timeout");
                test_done();
            end
        end
        repeat (4) @(posedge sys_clk);
    endtask

    function automatic logic [7:0] pat(int i);
        return 8'h81 ^ 8'(i * 17);
    endfunction

    initial begin
        {srst, system_release, remote_manual, trigger_active, unit_fault} <= 5'h10;
        {setpoint_ready, reg_wr, reg_rd, start} <= 4'h0;
        {reg_addr, reg_wdata, req_sel, req_data} <= 23'h000000;
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        check_bit("error_out", 1'b0, error_out);
        check_bit("panel_enable", 1'b1, panel_enable);
        check_byte("recipe_index", 8'h00, recipe_index);
        // Every selector code lands in its own slot while the stream is stalled
        for (int i = 0; i < 8; i++) begin
            send(3'(i), pat(i));
            reg_read(4'(i), rd);
            check_byte("slot", pat(i), rd);
        end
        check_byte("recipe_index", pat(6), recipe_index);
        check_bit("error_out", 1'b0, error_out);
        // Ninth word finds the stream full and raises the composite error
        send(psbp_pkg::SEL_POWDER, 8'h5a);
        reg_read(psbp_pkg::REG_STATUS, rd);
        check_byte("status", 8'h13, rd);
        reg_read(psbp_pkg::REG_COUNT, rd);
        check_byte("count", 8'h09, rd);
        check_bit("error_out", 1'b1, error_out);
        for (int i = 0; i < 8; i++) begin
            check_bit("setpoint_valid", 1'b1, setpoint_valid);
            check_byte("setpoint_sel", 8'(i), {5'h00, setpoint_sel});
            check_byte("setpoint_data", pat(i), setpoint_data);
            setpoint_ready <= 1'b1;
            @(posedge sys_clk);
            setpoint_ready <= 1'b0;
        end
        check_bit("setpoint_valid", 1'b0, setpoint_valid);
        reg_write(psbp_pkg::REG_STATUS, 8'h01);
        repeat (3) @(posedge sys_clk);
        check_bit("error_out", 1'b0, error_out);
        // Release and trigger combinations gate coating
        for (int k = 0; k < 4; k++) begin
            system_release <= k[0];
            trigger_active <= k[1];
            repeat (6) @(posedge sys_clk);
            check_bit("coating_enable", k[0] & k[1], coating_enable);
        end
        remote_manual <= 1'b1;
        repeat (6) @(posedge sys_clk);
        check_bit("remote_mode", 1'b1, remote_mode);
        reg_write(psbp_pkg::REG_CTRL, 8'h01);
        repeat (3) @(posedge sys_clk);
        check_bit("remote_mode", 1'b0, remote_mode);
        check_bit("panel_enable", 1'b0, panel_enable);
        reg_read(psbp_pkg::REG_CTRL, rd);
        check_byte("ctrl", 8'h01, rd);
        remote_manual <= 1'b0;
        repeat (6) @(posedge sys_clk);
        check_bit("panel_enable", 1'b1, panel_enable);
        reg_write(psbp_pkg::REG_CTRL, 8'h02);
        repeat (3) @(posedge sys_clk);
        check_bit("error_out", 1'b1, error_out);
        reg_write(psbp_pkg::REG_CTRL, 8'h00);
        unit_fault <= 1'b1;
        repeat (4) @(posedge sys_clk);
        check_bit("error_out", 1'b1, error_out);
        unit_fault <= 1'b0;
        reg_read(4'hf, rd);
        check_byte("unmapped", 8'h00, rd);
        test_done();
    end
endmodule
